/* verilog/abchf_pkg.sv */
// abchf_pkg: constants and carrier types of the reference enable and hit flag register bank
package abchf_pkg;

  // bus geometry
  localparam int unsigned AXI_ADDR_W         = 8;
  localparam int unsigned AXI_DATA_W         = 32;
  localparam int unsigned AXI_STRB_W         = AXI_DATA_W / 8;

  // register offsets (byte addresses)
  localparam logic [7:0]  REF_CFG_OFFSET     = 8'h00;
  localparam logic [7:0]  HIT_HIGH_OFFSET    = 8'h04;
  localparam logic [7:0]  REF_STATUS_OFFSET  = 8'h08;

  // reference configuration fields
  localparam int unsigned REF_CFG_W          = 4;
  localparam int unsigned REF_CORE_BIT       = 0;
  localparam int unsigned REF_CMP_BIT        = 1;
  localparam int unsigned REF_CONV_BIT       = 2;
  localparam int unsigned REF_USB_BIT        = 3;
  localparam logic [3:0]  REF_CFG_RST        = 4'h0;

  // status fields: ready flags low, on flags above them
  localparam int unsigned STAT_READY_LSB     = 0;
  localparam int unsigned STAT_ON_LSB        = 4;

  // hit flag fields
  localparam int unsigned HIT_W              = 10;
  localparam int unsigned HIT_FIRST_CHANNEL  = 16;
  localparam logic [9:0]  HIT_RST            = 10'h000;
  localparam logic [1:0]  CM_WRITE_OR_MATCH  = 2'h3;

  // bus responses
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // timing
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned REF_STARTUP_MS     = 1;
  localparam int unsigned REF_STARTUP_CYCLES = REF_STARTUP_MS * 1000 * CLK_MHZ;

  // converter events for channels 16 upward, one bit per channel
  typedef struct packed {
    logic [HIT_W-1:0] match;
    logic [HIT_W-1:0] buf_written;
  } abchf_hit_evt_t;

  // per-consumer reference state
  typedef struct packed {
    logic [REF_CFG_W-1:0] on;
    logic [REF_CFG_W-1:0] ready;
  } abchf_ref_state_t;

  function automatic logic [AXI_DATA_W-1:0] strb_to_mask(input logic [AXI_STRB_W-1:0] strb);
    logic [AXI_DATA_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < AXI_STRB_W; i++)
    begin
      mask[i*8 +: 8] = {8{strb[i]}};
    end
    return mask;
  endfunction : strb_to_mask

endpackage : abchf_pkg

/* verilog/abchf_ref_timer.sv */
// abchf_ref_timer: one reference consumer, on-state and start-up delay count
`timescale 1ns/1ps
module abchf_ref_timer #(
  parameter int unsigned STARTUP_CYCLES = abchf_pkg::REF_STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // enable sources
  input  wire logic sw_enable,
  input  wire logic module_request,
  // reference state
  output logic      ref_on,
  output logic      ref_ready
);

  localparam int unsigned      CNT_W  = $clog2(STARTUP_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST_C = CNT_W'(STARTUP_CYCLES - 1);

  if (STARTUP_CYCLES < 1)
  begin : g_bad_cycles
    $error("abchf_ref_timer: STARTUP_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic             on;
    logic             ready;
    logic [CNT_W-1:0] cnt;
  } abchf_tmr_state_t;

  abchf_tmr_state_t st_ff;
  abchf_tmr_state_t nxt_st;

  always_comb
  begin
    nxt_st    = st_ff;
    // either source keeps the reference running
    nxt_st.on = sw_enable | module_request;
    if (!nxt_st.on)
    begin
      nxt_st.ready = 1'b0;
      nxt_st.cnt   = '0;
    end
    else if (st_ff.on && !st_ff.ready)
    begin
      // usable only once the full delay has run since switch-on
      if (st_ff.cnt == LAST_C)
      begin
        nxt_st.ready = 1'b1;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign ref_on    = st_ff.on;
  assign ref_ready = st_ff.ready;

endmodule : abchf_ref_timer

/* verilog/abchf_hit_flags.sv */
// abchf_hit_flags: sticky compare hit flags for result channels 16 to 25
`timescale 1ns/1ps
module abchf_hit_flags (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // converter side
  input  wire logic [1:0]                     compare_mode_field,
  input  wire abchf_pkg::abchf_hit_evt_t      hit_evt,
  // software write
  input  wire logic                           sw_wr,
  input  wire logic [abchf_pkg::HIT_W-1:0]    sw_mask,
  input  wire logic [abchf_pkg::HIT_W-1:0]    sw_data,
  // flags
  output logic      [abchf_pkg::HIT_W-1:0]    hit_flags_upper
);

  typedef struct packed {
    logic [abchf_pkg::HIT_W-1:0] flags;
  } abchf_hit_state_t;

  abchf_hit_state_t                st_ff;
  abchf_hit_state_t                nxt_st;
  logic [abchf_pkg::HIT_W-1:0]     set_vec;

  // only real result channels reach here; internal selections have no event line
  for (genvar ch = 0; ch < abchf_pkg::HIT_W; ch++)
  begin : g_set
    assign set_vec[ch] = hit_evt.match[ch] |
      ((compare_mode_field == abchf_pkg::CM_WRITE_OR_MATCH) & hit_evt.buf_written[ch]);
  end

  always_comb
  begin
    nxt_st = st_ff;
    if (sw_wr)
    begin
      nxt_st.flags = (st_ff.flags & ~sw_mask) | (sw_data & sw_mask);
    end
    // a hit in the clearing cycle is kept
    nxt_st.flags = nxt_st.flags | set_vec;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff.flags <= abchf_pkg::HIT_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign hit_flags_upper = st_ff.flags;

endmodule : abchf_hit_flags

/* verilog/abchf_top.sv */
// abchf_top: axi4-lite register bank for reference enables and upper compare hit flags
`timescale 1ns/1ps
module abchf_top #(
  parameter int unsigned STARTUP_CYCLES   = abchf_pkg::REF_STARTUP_CYCLES,
  parameter bit          HIGH_HIT_PRESENT = 1'b1
) (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  // axi4-lite write address
  input  wire logic [abchf_pkg::AXI_ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [abchf_pkg::AXI_DATA_W-1:0]      s_axi_wdata,
  input  wire logic [abchf_pkg::AXI_STRB_W-1:0]      s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]                            s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [abchf_pkg::AXI_ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  // axi4-lite read data
  output logic      [abchf_pkg::AXI_DATA_W-1:0]      s_axi_rdata,
  output logic      [1:0]                            s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  // converter events
  input  wire logic [1:0]                            compare_mode_field,
  input  wire abchf_pkg::abchf_hit_evt_t             hit_evt,
  // reference requests from consumers: core, cmp, converter, usb
  input  wire logic [abchf_pkg::REF_CFG_W-1:0]       ref_request,
  // reference state per consumer
  output logic      [abchf_pkg::REF_CFG_W-1:0]       ref_on,
  output logic      [abchf_pkg::REF_CFG_W-1:0]       ref_ready,
  // hit flags for channels 25 down to 16
  output logic      [abchf_pkg::HIT_W-1:0]           hit_flags_upper
);

  if (STARTUP_CYCLES < 1)
  begin : g_bad_startup
    $error("abchf_top: STARTUP_CYCLES must be at least 1");
  end

  // bus-facing state
  typedef struct packed {
    logic [abchf_pkg::REF_CFG_W-1:0]  ref_cfg;
    logic                             aw_held;
    logic [abchf_pkg::AXI_ADDR_W-1:0] awaddr;
    logic                             w_held;
    logic [abchf_pkg::AXI_DATA_W-1:0] wdata;
    logic [abchf_pkg::AXI_STRB_W-1:0] wstrb;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             rvalid;
    logic [abchf_pkg::AXI_DATA_W-1:0] rdata;
    logic [1:0]                       rresp;
  } abchf_bus_state_t;

  abchf_bus_state_t                    st_ff;
  abchf_bus_state_t                    nxt_st;
  abchf_pkg::abchf_ref_state_t         ref_st;
  logic [abchf_pkg::HIT_W-1:0]         hit_vec;
  logic                                hit_wr;
  logic [abchf_pkg::HIT_W-1:0]         hit_wr_mask;
  logic [abchf_pkg::HIT_W-1:0]         hit_wr_data;
  logic                                write_go;
  logic [abchf_pkg::AXI_DATA_W-1:0]    wr_mask;
  logic [abchf_pkg::AXI_DATA_W-1:0]    rd_word;
  logic [1:0]                          rd_resp;

  // handshakes: one write and one read in flight at a time
  assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;

  // a write is carried out once both halves are held
  assign write_go = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  assign wr_mask  = abchf_pkg::strb_to_mask(st_ff.wstrb);

  // hit register write path, only while the register is built in
  always_comb
  begin
    hit_wr      = 1'b0;
    hit_wr_mask = wr_mask[abchf_pkg::HIT_W-1:0];
    hit_wr_data = st_ff.wdata[abchf_pkg::HIT_W-1:0];
    if (write_go && HIGH_HIT_PRESENT && (st_ff.awaddr == abchf_pkg::HIT_HIGH_OFFSET))
    begin
      hit_wr = 1'b1;
    end
  end

  // read decode
  always_comb
  begin
    rd_word = '0;
    rd_resp = abchf_pkg::RESP_OKAY;
    if (s_axi_araddr == abchf_pkg::REF_CFG_OFFSET)
    begin
      // upper bits stay zero
      rd_word[abchf_pkg::REF_CFG_W-1:0] = st_ff.ref_cfg;
    end
    else if (HIGH_HIT_PRESENT && (s_axi_araddr == abchf_pkg::HIT_HIGH_OFFSET))
    begin
      rd_word[abchf_pkg::HIT_W-1:0] = hit_vec;
    end
    else if (s_axi_araddr == abchf_pkg::REF_STATUS_OFFSET)
    begin
      rd_word[abchf_pkg::STAT_READY_LSB +: abchf_pkg::REF_CFG_W] = ref_st.ready;
      rd_word[abchf_pkg::STAT_ON_LSB +: abchf_pkg::REF_CFG_W]    = ref_st.on;
    end
    else
    begin
      // absent hit register answers like any hole in the map
      rd_resp = abchf_pkg::RESP_SLVERR;
    end
  end

  // next state of the bus side and the configuration bits
  always_comb
  begin
    nxt_st = st_ff;

    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr  = s_axi_awaddr;
    end

    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata  = s_axi_wdata;
      nxt_st.wstrb  = s_axi_wstrb;
    end

    if (write_go)
    begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = abchf_pkg::RESP_OKAY;
      if (st_ff.awaddr == abchf_pkg::REF_CFG_OFFSET)
      begin
        // only the four enable bits exist; the rest of the word is dropped
        nxt_st.ref_cfg = (st_ff.ref_cfg & ~wr_mask[abchf_pkg::REF_CFG_W-1:0]) |
                         (st_ff.wdata[abchf_pkg::REF_CFG_W-1:0] &
                          wr_mask[abchf_pkg::REF_CFG_W-1:0]);
      end
      else if (HIGH_HIT_PRESENT && (st_ff.awaddr == abchf_pkg::HIT_HIGH_OFFSET))
      begin
        // flags themselves are updated inside the hit block
        nxt_st.bresp = abchf_pkg::RESP_OKAY;
      end
      else if (st_ff.awaddr == abchf_pkg::REF_STATUS_OFFSET)
      begin
        // status is read-only; the write is accepted and dropped
        nxt_st.bresp = abchf_pkg::RESP_OKAY;
      end
      else
      begin
        nxt_st.bresp = abchf_pkg::RESP_SLVERR;
      end
    end
    else if (st_ff.bvalid && s_axi_bready)
    begin
      nxt_st.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_word;
      nxt_st.rresp  = rd_resp;
    end
    else if (st_ff.rvalid && s_axi_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff         <= '0;
      st_ff.ref_cfg <= abchf_pkg::REF_CFG_RST;
      st_ff.bresp   <= abchf_pkg::RESP_OKAY;
      st_ff.rresp   <= abchf_pkg::RESP_OKAY;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // one timer per consumer; bit order matches the configuration register
  // core services, comparators and charge unit, converter, usb
  for (genvar i = 0; i < abchf_pkg::REF_CFG_W; i++)
  begin : g_ref
    abchf_ref_timer #(
      .STARTUP_CYCLES (STARTUP_CYCLES)
    ) u_timer (
      .clk            (clk),
      .rst            (rst),
      .sw_enable      (st_ff.ref_cfg[i]),
      .module_request (ref_request[i]),
      .ref_on         (ref_st.on[i]),
      .ref_ready      (ref_st.ready[i])
    );
  end

  // the smallest package variant builds without the upper hit register
  if (HIGH_HIT_PRESENT)
  begin : g_hit
    abchf_hit_flags u_hits (
      .clk                (clk),
      .rst                (rst),
      .compare_mode_field (compare_mode_field),
      .hit_evt            (hit_evt),
      .sw_wr              (hit_wr),
      .sw_mask            (hit_wr_mask),
      .sw_data            (hit_wr_data),
      .hit_flags_upper    (hit_vec)
    );
  end
  else
  begin : g_no_hit
    assign hit_vec = '0;
  end

  // outputs
  assign s_axi_bvalid    = st_ff.bvalid;
  assign s_axi_bresp     = st_ff.bresp;
  assign s_axi_rvalid    = st_ff.rvalid;
  assign s_axi_rdata     = st_ff.rdata;
  assign s_axi_rresp     = st_ff.rresp;
  assign ref_on          = ref_st.on;
  assign ref_ready       = ref_st.ready;
  assign hit_flags_upper = hit_vec;

endmodule : abchf_top

/* verification/abchf_top_asserts.sv */
// checker: concurrent properties for the reference and hit flag bank
`timescale 1ns/1ps
module abchf_top_asserts #(
  parameter int unsigned STARTUP_CYCLES = 8
) (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  // register bus
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [7:0]                s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  // converter and reference side
  input wire logic [1:0]                compare_mode_field,
  input wire abchf_pkg::abchf_hit_evt_t hit_evt,
  input wire logic [3:0]                ref_request,
  input wire logic [3:0]                ref_on,
  input wire logic [3:0]                ref_ready,
  input wire logic [9:0]                hit_flags_upper
);
  int         cnt [4];
  logic [3:0] at_s;
  logic [3:0] past_s;
  logic [9:0] set_src;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // cycles since each reference came on, saturating just past the delay
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (rst || !ref_on[i])
        cnt[i] <= 0;
      else if (cnt[i] <= int'(STARTUP_CYCLES))
        cnt[i] <= cnt[i] + 1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      at_s[i] = (cnt[i] == int'(STARTUP_CYCLES));
      past_s[i] = (cnt[i] == int'(STARTUP_CYCLES) + 1);
    end
  end

  assign set_src = hit_evt.match | ({10{compare_mode_field == 2'h3}} & hit_evt.buf_written);

  property p_req_on;
    (ref_request != 4'h0) |=> ((ref_on & $past(ref_request)) == $past(ref_request));
  endproperty
  a_req_on: assert property (p_req_on) else $error("reference not on after request");

  property p_ready_on;
    (ref_ready & ~ref_on) == 4'h0;
  endproperty
  a_ready_on: assert property (p_ready_on) else $error("ready without reference on");

  property p_ready_early;
    ((ref_ready & ~$past(ref_ready)) & ~at_s) == 4'h0;
  endproperty
  a_ready_early: assert property (p_ready_early) else $error("ready at wrong cycle");

  property p_ready_late;
    (past_s & ref_on & ~ref_ready) == 4'h0;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready missing after delay");

  property p_hit_set;
    (set_src != 10'h000) |=> ((hit_flags_upper & $past(set_src)) == $past(set_src));
  endproperty
  a_hit_set: assert property (p_hit_set) else $error("hit flag not set");

  property p_hit_cause;
    !$past(rst) && !$rose(s_axi_bvalid)
      |-> ((hit_flags_upper & ~$past(hit_flags_upper) & ~$past(set_src)) == 10'h000);
  endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("hit flag set without cause");

  property p_hit_keep;
    !$past(rst) && !$rose(s_axi_bvalid) |-> (($past(hit_flags_upper) & ~hit_flags_upper) == 10'h000);
  endproperty
  a_hit_keep: assert property (p_hit_keep) else $error("hit flag lost without write");

  property p_cfg_upper;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == 8'h00) |=> s_axi_rdata[31:4] == 28'h0000000;
  endproperty
  a_cfg_upper: assert property (p_cfg_upper) else $error("config upper bits not zero");

  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");

  c_hit: cover property ((set_src != 10'h000) ##1 (hit_flags_upper != 10'h000));
  c_ready: cover property ($rose(ref_ready[0]));
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : abchf_top_asserts

bind abchf_top abchf_top_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_abchf_top_asserts (.*);

/* verification/tb_top.sv */
// tb_top: directed bench for the reference and hit flag bank
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned SC = 8;
  localparam logic [1:0]  OK = abchf_pkg::RESP_OKAY;
  localparam logic [1:0]  ER = abchf_pkg::RESP_SLVERR;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic [7:0]                s_axi_awaddr, s_axi_araddr;
  logic [31:0]               s_axi_wdata, s_axi_rdata;
  logic [3:0]                s_axi_wstrb, ref_request, ref_on, ref_ready;
  logic [1:0]                s_axi_bresp, s_axi_rresp, compare_mode_field;
  logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                      s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                      s_axi_rvalid, s_axi_rready;
  logic [9:0]                hit_flags_upper;
  abchf_pkg::abchf_hit_evt_t hit_evt;
  int                        n_errors = 0;
  int                        comparisons = 0;

  always #2 clk = ~clk;

  abchf_top #(.STARTUP_CYCLES(SC)) i_abchf_top (.*);

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // master holds each channel until its own ready, bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic ev(input logic [9:0] m, input logic [9:0] b);
    @(posedge clk);
    hit_evt.match <= m;
    hit_evt.buf_written <= b;
    @(posedge clk);
    hit_evt <= '0;
    @(posedge clk);
  endtask : ev

  task automatic t_reset;
    rd(8'h00, 32'h0, OK);
    rd(8'h04, 32'h0, OK);
    rd(8'h08, 32'h0, OK);
  endtask : t_reset

  task automatic t_cfg;
    wr(8'h00, 32'hFFFFFFFF, 4'hF, OK);
    rd(8'h00, 32'h0000000F, OK);
    chk("ref_on", 32'hF, {28'h0, ref_on});
    cyc(SC);
    chk("ref_ready", 32'hF, {28'h0, ref_ready});
    rd(8'h08, 32'h000000FF, OK);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'h1 << i, 4'hF, OK);
      cyc(2);
      chk("ref_on", 32'h1 << i, {28'h0, ref_on});
    end
    wr(8'h00, 32'h0, 4'hF, OK);
    cyc(2);
    chk("ref_on", 32'h0, {28'h0, ref_on});
  endtask : t_cfg

  task automatic t_req;
    ref_request <= 4'h5;
    cyc(2);
    chk("ref_on", 32'h5, {28'h0, ref_on});
    chk("ref_ready", 32'h0, {28'h0, ref_ready});
    cyc(SC);
    chk("ref_ready", 32'h5, {28'h0, ref_ready});
    wr(8'h00, 32'h2, 4'hF, OK);
    cyc(SC + 1);
    ref_request <= 4'h7;
    cyc(1);
    chk("ref_ready", 32'h7, {28'h0, ref_ready});
    ref_request <= 4'h0;
    wr(8'h00, 32'h0, 4'hF, OK);
    cyc(2);
    chk("ref_on", 32'h0, {28'h0, ref_on});
  endtask : t_req

  task automatic t_hits;
    for (int c = 0; c < 3; c++)
    begin
      compare_mode_field <= c[1:0];
      ev(10'h000, 10'h001);
      chk("hits", 32'h0, {22'h0, hit_flags_upper});
    end
    ev(10'h200, 10'h000);
    chk("hits", 32'h200, {22'h0, hit_flags_upper});
    compare_mode_field <= 2'h3;
    ev(10'h000, 10'h002);
    rd(8'h04, 32'h202, OK);
    wr(8'h04, 32'hFFFFFFFF, 4'h2, OK);
    chk("hits", 32'h302, {22'h0, hit_flags_upper});
    wr(8'h04, 32'hFFFFFFFF, 4'hF, OK);
    rd(8'h04, 32'h3FF, OK);
    wr(8'h04, 32'h0, 4'hF, OK);
    chk("hits", 32'h0, {22'h0, hit_flags_upper});
    // event lands at the very edge of a clearing write: the set must win
    fork
      wr(8'h04, 32'h0, 4'hF, OK);
      begin
        cyc(1);
        ev(10'h010, 10'h000);
      end
    join
    chk("hits", 32'h010, {22'h0, hit_flags_upper});
  endtask : t_hits

  task automatic t_bad;
    wr(8'h0C, 32'hF, 4'hF, ER);
    rd(8'h0C, 32'h0, ER);
    wr(8'h01, 32'hF, 4'hF, ER);
    rd(8'h00, 32'h0, OK);
    wr(8'h08, 32'hFF, 4'hF, OK);
    rd(8'h08, 32'h0, OK);
  endtask : t_bad

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    ref_request = 4'h0;
    compare_mode_field = 2'h0;
    hit_evt = '0;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_cfg();
    t_req();
    t_hits();
    t_bad();
    complete_run();
  end

  // hang guard, far beyond the directed sequence
  initial
  begin
    cyc(5000);
    n_errors++;
    complete_run();
  end
endmodule : tb_top
